// ==== inc/mac_pause_ptp_pkg.sv ====
package mac_pause_ptp_pkg;

  // widths and slot layout
  localparam int QUANTA_W    = 16;
  localparam int PRIO_N      = 8;
  localparam int SLOT_N      = 9;
  localparam int GLOBAL_SLOT = 8;
  localparam int TIMER_W     = 80;
  localparam int CORR_W      = 64;
  localparam int TRIM_W      = 11;

  // normal clock format fields
  localparam int SEC_LSB = 32;
  localparam int SEC_W   = 48;
  localparam int NS_W    = 32;
  localparam logic [32:0] NS_PER_SEC = 33'h03B9ACA00;

  // transparent clock format fields
  localparam int TC_SIGN   = 63;
  localparam int TC_NS_LSB = 16;
  localparam int TC_NS_W   = 47;
  localparam int TC_FRAC_W = 16;

  // trim fields: whole nanoseconds above three fraction bits
  localparam int TRIM_NS_LSB = 3;
  localparam int TRIM_NS_W   = 8;
  localparam int TRIM_FR_W   = 3;

  // register byte offsets
  localparam logic [31:0] OFF_CTRL      = 32'h0000_0000;
  localparam logic [31:0] OFF_TRIM      = 32'h0000_0004;
  localparam logic [31:0] OFF_INT_STAT  = 32'h0000_0008;
  localparam logic [31:0] OFF_INT_CLEAR = 32'h0000_000C;
  localparam logic [31:0] OFF_INT_EN    = 32'h0000_0010;
  localparam logic [31:0] OFF_PAUSE_REQ = 32'h0000_0014;

  // control bits
  localparam int CTRL_W        = 2;
  localparam int CTRL_ONE_STEP = 0;
  localparam int CTRL_TRANSP   = 1;

  // interrupt bits
  localparam int INT_W          = 5;
  localparam int INT_PAUSE_RX   = 0;
  localparam int INT_PAUSE_DONE = 1;
  localparam int INT_TX_STAMP   = 2;
  localparam int INT_RX_STAMP   = 3;
  localparam int INT_TX_DROP    = 4;

  // reset values
  localparam logic [CTRL_W-1:0] RST_CTRL   = 2'h0;
  localparam logic [TRIM_W-1:0] RST_TRIM   = 11'h000;
  localparam logic [INT_W-1:0]  RST_INT_EN = 5'h00;

  // bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [1:0] {
    PTP_NOP      = 2'h0,
    PTP_ONE_STEP = 2'h1,
    PTP_TWO_STEP = 2'h2,
    PTP_RSVD     = 2'h3
  } ptp_op_e;

endpackage

// ==== design/pause_slot.sv ====
`timescale 1ns/1ns
// one pause class: held quanta, sticky request and valid pulse
module pause_slot (
  input  wire logic                                  clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  ce,
  input  wire logic                                  capture,
  input  wire logic [mac_pause_ptp_pkg::QUANTA_W-1:0] quantaIn,
  input  wire logic                                  done,
  output logic      [mac_pause_ptp_pkg::QUANTA_W-1:0] quanta,
  output logic                                       req,
  output logic                                       valid
);

  // quanta stay until the next frame for this class
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      quanta <= 16'h0000;
    else if (ce && capture)
      quanta <= quantaIn;
  end

  // a new frame in the finishing cycle keeps the request up
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      req <= 1'b0;
    else if (ce)
    begin
      if (capture)
        req <= 1'b1;
      else if (done)
        req <= 1'b0;
    end
  end

  // one-cycle mark that quanta are fresh
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      valid <= 1'b0;
    else if (ce)
      valid <= capture;
  end

endmodule

// ==== design/ptp_time_adder.sv ====
`timescale 1ns/1ns
// registered add of a time offset in normal or transparent format
module ptp_time_adder (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   ce,
  input  wire logic                                   start,
  input  wire logic                                   transparent,
  input  wire logic [mac_pause_ptp_pkg::TIMER_W-1:0]   base,
  input  wire logic [mac_pause_ptp_pkg::TC_NS_W-1:0]   addNs,
  input  wire logic [mac_pause_ptp_pkg::TC_FRAC_W-1:0] addFrac,
  output logic      [mac_pause_ptp_pkg::TIMER_W-1:0]   sum,
  output logic                                        done
);

  function automatic logic [79:0] addTime(input logic [79:0] b, input logic tc,
                                          input logic [46:0] ns, input logic [15:0] fr);
    logic [32:0] nsSum;
    logic [62:0] tcSum;
    nsSum = {1'b0, b[31:0]} + {1'b0, ns[31:0]};
    tcSum = b[62:0] + {ns, fr};
    if (tc)
      addTime = {b[79:64], 1'b0, tcSum};
    else if (nsSum >= mac_pause_ptp_pkg::NS_PER_SEC)
      addTime = {b[79:32] + 48'h0000_0000_0001,
                 32'(nsSum - mac_pause_ptp_pkg::NS_PER_SEC)};
    else
      addTime = {b[79:32], nsSum[31:0]};
  endfunction

  // result and its one-cycle done mark
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sum  <= '0;
      done <= 1'b0;
    end
    else if (ce)
    begin
      done <= start;
      if (start)
        sum <= addTime(base, transparent, addNs, addFrac);
    end
  end

endmodule

// ==== design/mac_pause_ptp.sv ====
`timescale 1ns/1ns
// pause report and timestamp inputs with an AHB-Lite register slave
module mac_pause_ptp (
  input  wire logic                                                  clk,
  input  wire logic                                                  rst_n,
  input  wire logic                                                  ce,
  // register bus
  input  wire logic                                                  hsel,
  input  wire logic [31:0]                                           haddr,
  input  wire logic [1:0]                                            htrans,
  input  wire logic                                                  hwrite,
  input  wire logic [2:0]                                            hsize,
  input  wire logic [31:0]                                           hwdata,
  input  wire logic                                                  hready,
  output logic                                                       hreadyout,
  output logic      [31:0]                                           hrdata,
  output logic                                                       hresp,
  // received pause frames from the parser
  input  wire logic                                                  rxPauseFrame,
  input  wire logic                                                  rxPauseGlobal,
  input  wire logic [mac_pause_ptp_pkg::PRIO_N-1:0]                  rxPauseClassMask,
  input  wire logic [mac_pause_ptp_pkg::PRIO_N-1:0][15:0]            rxPauseQuanta,
  input  wire logic [mac_pause_ptp_pkg::QUANTA_W-1:0]                rxGlobalQuantaIn,
  input  wire logic [mac_pause_ptp_pkg::SLOT_N-1:0]                  pauseDone,
  // pause report to the client
  output logic      [mac_pause_ptp_pkg::SLOT_N-1:0]                  rxPauseReq,
  output logic      [mac_pause_ptp_pkg::SLOT_N-1:0]                  rxPauseValid,
  output logic      [mac_pause_ptp_pkg::PRIO_N-1:0][15:0]            rxPriorityQuantaOut,
  output logic      [mac_pause_ptp_pkg::QUANTA_W-1:0]                rxGlobalQuantaOut,
  // timers and frame starts
  input  wire logic [mac_pause_ptp_pkg::TIMER_W-1:0]                 txSystemTimer,
  input  wire logic [mac_pause_ptp_pkg::TIMER_W-1:0]                 rxSystemTimer,
  input  wire logic                                                  txFrameStart,
  input  wire logic [1:0]                                            txPtpOp,
  input  wire logic [15:0]                                           txPtpTag,
  input  wire logic [mac_pause_ptp_pkg::CORR_W-1:0]                  txCorrection,
  input  wire logic                                                  rxFrameStart,
  // timestamps
  output logic      [mac_pause_ptp_pkg::TIMER_W-1:0]                 txTwoStepStamp,
  output logic      [mac_pause_ptp_pkg::TIMER_W-1:0]                 txOneStepStamp,
  output logic                                                       txStampValid,
  output logic                                                       txStampOneStep,
  output logic      [15:0]                                           txStampTag,
  output logic      [mac_pause_ptp_pkg::TIMER_W-1:0]                 rxStamp,
  output logic                                                       rxStampValid,
  output logic                                                       irq
);

  typedef enum logic [1:0] {TX_IDLE, TX_BASE, TX_TRIM} tx_state_e;

  // read-back mux over the register map
  function automatic logic [31:0] readReg(input logic [31:0] a,
                                          input logic [1:0] c,
                                          input logic [10:0] t,
                                          input logic [4:0] s,
                                          input logic [4:0] e,
                                          input logic [8:0] r);
    readReg = 32'h0000_0000;
    unique case (a)
      mac_pause_ptp_pkg::OFF_CTRL:      readReg = {30'h0000_0000, c};
      mac_pause_ptp_pkg::OFF_TRIM:      readReg = {21'h00_0000, t};
      mac_pause_ptp_pkg::OFF_INT_STAT:  readReg = {27'h000_0000, s};
      mac_pause_ptp_pkg::OFF_INT_EN:    readReg = {27'h000_0000, e};
      mac_pause_ptp_pkg::OFF_PAUSE_REQ: readReg = {23'h00_0000, r};
      default:                          readReg = 32'h0000_0000;
    endcase
  endfunction

  // trim nanoseconds widened to the adder field
  function automatic logic [46:0] trimNs(input logic [10:0] t);
    trimNs = {39'h00_0000_0000, t[10:3]};
  endfunction

  logic                    busPending;
  logic                    busWrite;
  logic [31:0]             busAddr;
  logic                    busAccept;
  logic                    regWrite;
  logic [1:0]              ctrl;
  logic [10:0]             trim;
  logic [4:0]              intStat;
  logic [4:0]              intEn;
  logic [4:0]              intClear;
  logic [4:0]              events;
  logic [8:0]              slotCapture;
  logic [8:0][15:0]        slotQuanta;
  logic [8:0][15:0]        slotQuantaOut;
  tx_state_e               txState;
  logic                    txOpValid;
  logic                    txWantOneStep;
  logic                    baseStart;
  logic                    baseDone;
  logic [46:0]             baseAddNs;
  logic [15:0]             baseAddFrac;
  logic                    trimStart;
  logic                    trimDone;
  logic [15:0]             trimFrac;
  logic                    oneStepEnable;
  logic                    transparentSel;

  assign oneStepEnable  = ctrl[mac_pause_ptp_pkg::CTRL_ONE_STEP];
  assign transparentSel = ctrl[mac_pause_ptp_pkg::CTRL_TRANSP];

  // bus: one wait state per transfer, word accesses only
  assign busAccept = hsel && hready && (htrans == mac_pause_ptp_pkg::HTRANS_NONSEQ)
                     && (hsize == mac_pause_ptp_pkg::HSIZE_WORD);
  assign regWrite  = busPending && busWrite;

  // address phase capture and ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busPending <= 1'b0;
      busWrite   <= 1'b0;
      busAddr    <= 32'h0000_0000;
      hreadyout  <= 1'b1;
    end
    else if (ce)
    begin
      busPending <= busAccept;
      hreadyout  <= !busAccept;
      if (busAccept)
      begin
        busWrite <= hwrite;
        busAddr  <= haddr;
      end
    end
  end

  // read data registered in the data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else if (ce && busPending && !busWrite)
      hrdata <= readReg(busAddr, ctrl, trim, intStat, intEn, rxPauseReq);
  end

  // response is always okay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hresp <= 1'b0;
    else if (ce)
      hresp <= 1'b0;
  end

  // control register: one-step enable and transparent select
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= mac_pause_ptp_pkg::RST_CTRL;
    else if (ce && regWrite && busAddr == mac_pause_ptp_pkg::OFF_CTRL)
      ctrl <= hwdata[1:0];
  end

  // latency trim register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trim <= mac_pause_ptp_pkg::RST_TRIM;
    else if (ce && regWrite && busAddr == mac_pause_ptp_pkg::OFF_TRIM)
      trim <= hwdata[10:0];
  end

  // interrupt enable register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      intEn <= mac_pause_ptp_pkg::RST_INT_EN;
    else if (ce && regWrite && busAddr == mac_pause_ptp_pkg::OFF_INT_EN)
      intEn <= hwdata[4:0];
  end

  // clear strobes from the write-only clear register
  assign intClear = (regWrite && busAddr == mac_pause_ptp_pkg::OFF_INT_CLEAR)
                    ? hwdata[4:0] : 5'h00;

  // events feeding the sticky status
  always_comb
  begin
    events = 5'h00;
    events[mac_pause_ptp_pkg::INT_PAUSE_RX]   = |slotCapture;
    events[mac_pause_ptp_pkg::INT_PAUSE_DONE] = |(rxPauseReq & pauseDone & ~slotCapture);
    events[mac_pause_ptp_pkg::INT_TX_STAMP]   = txStampValid;
    events[mac_pause_ptp_pkg::INT_RX_STAMP]   = rxStampValid;
    events[mac_pause_ptp_pkg::INT_TX_DROP]    = txFrameStart && txOpValid
                                                && txState != TX_IDLE;
  end

  // sticky status, a new event wins over a clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      intStat <= 5'h00;
    else if (ce)
      intStat <= (intStat & ~intClear) | events;
  end

  // level interrupt from enabled status bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else if (ce)
      irq <= |(((intStat & ~intClear) | events) & intEn);
  end

  // route frames to slots: priority classes by mask, standard to slot eight
  always_comb
  begin
    slotCapture = 9'h000;
    slotQuanta  = '0;
    for (int i = 0; i < mac_pause_ptp_pkg::PRIO_N; i++)
    begin
      slotCapture[i] = rxPauseFrame && !rxPauseGlobal && rxPauseClassMask[i];
      slotQuanta[i]  = rxPauseQuanta[i];
    end
    slotCapture[mac_pause_ptp_pkg::GLOBAL_SLOT] = rxPauseFrame && rxPauseGlobal;
    slotQuanta[mac_pause_ptp_pkg::GLOBAL_SLOT]  = rxGlobalQuantaIn;
  end

  // nine pause slots, one per quanta output
  for (genvar g = 0; g < mac_pause_ptp_pkg::SLOT_N; g++)
  begin : gSlot
    pause_slot uSlot (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .capture  (slotCapture[g]),
      .quantaIn (slotQuanta[g]),
      .done     (pauseDone[g]),
      .quanta   (slotQuantaOut[g]),
      .req      (rxPauseReq[g]),
      .valid    (rxPauseValid[g])
    );
  end

  // split the slot quanta onto the nine outputs
  always_comb
  begin
    for (int i = 0; i < mac_pause_ptp_pkg::PRIO_N; i++)
      rxPriorityQuantaOut[i] = slotQuantaOut[i];
    rxGlobalQuantaOut = slotQuantaOut[mac_pause_ptp_pkg::GLOBAL_SLOT];
  end

  // only one-step and two-step requests take a stamp
  assign txOpValid = (txPtpOp == mac_pause_ptp_pkg::PTP_ONE_STEP)
                     || (txPtpOp == mac_pause_ptp_pkg::PTP_TWO_STEP);
  assign baseStart = (txState == TX_IDLE) && txFrameStart && txOpValid;
  assign trimStart = (txState == TX_BASE) && baseDone && txWantOneStep;

  // correction is added only in transparent mode
  assign baseAddNs   = transparentSel ? txCorrection[62:16] : 47'h0000_0000_0000;
  assign baseAddFrac = transparentSel ? txCorrection[15:0] : 16'h0000;
  assign trimFrac    = transparentSel ? {trim[2:0], 13'h0000} : 16'h0000;

  // two-step stamp: timer sampled straight, it is already on this clock
  ptp_time_adder uBase (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .start       (baseStart),
    .transparent (transparentSel),
    .base        (txSystemTimer),
    .addNs       (baseAddNs),
    .addFrac     (baseAddFrac),
    .sum         (txTwoStepStamp),
    .done        (baseDone)
  );

  // one-step stamp: two-step stamp plus latency trim
  ptp_time_adder uTrim (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (ce),
    .start       (trimStart),
    .transparent (transparentSel),
    .base        (txTwoStepStamp),
    .addNs       (trimNs(trim)),
    .addFrac     (trimFrac),
    .sum         (txOneStepStamp),
    .done        (trimDone)
  );

  // stamp sequencer; requests while busy are dropped and flagged
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txState       <= TX_IDLE;
      txWantOneStep <= 1'b0;
      txStampTag    <= 16'h0000;
    end
    else if (ce)
    begin
      unique case (txState)
        TX_IDLE:
          if (baseStart)
          begin
            txState       <= TX_BASE;
            txStampTag    <= txPtpTag;
            txWantOneStep <= (txPtpOp == mac_pause_ptp_pkg::PTP_ONE_STEP)
                             && oneStepEnable;
          end
        TX_BASE:
          if (baseDone)
            txState <= txWantOneStep ? TX_TRIM : TX_IDLE;
        TX_TRIM:
          if (trimDone)
            txState <= TX_IDLE;
      endcase
    end
  end

  // completion pulse with the kind of stamp
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txStampValid   <= 1'b0;
      txStampOneStep <= 1'b0;
    end
    else if (ce)
    begin
      txStampValid   <= (txState == TX_BASE && baseDone && !txWantOneStep)
                        || (txState == TX_TRIM && trimDone);
      txStampOneStep <= (txState == TX_TRIM && trimDone);
    end
  end

  // receive stamp from its own timer, already on this clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxStamp      <= '0;
      rxStampValid <= 1'b0;
    end
    else if (ce)
    begin
      rxStampValid <= rxFrameStart;
      if (rxFrameStart)
        rxStamp <= rxSystemTimer;
    end
  end

endmodule

// ==== testbench/mac_pause_ptp_monitor.sv ====
`timescale 1ns/1ns
// watches bus, pause report and stamp ports of the block
module mac_pause_ptp_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [1:0]  htrans,
  input wire logic [2:0]  hsize,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxPauseFrame,
  input wire logic        rxPauseGlobal,
  input wire logic [7:0]  rxPauseClassMask,
  input wire logic [15:0] rxGlobalQuantaIn,
  input wire logic [8:0]  pauseDone,
  input wire logic [8:0]  rxPauseReq,
  input wire logic [8:0]  rxPauseValid,
  input wire logic [15:0] rxGlobalQuantaOut,
  input wire logic [79:0] txSystemTimer,
  input wire logic [79:0] rxSystemTimer,
  input wire logic        txFrameStart,
  input wire logic [1:0]  txPtpOp,
  input wire logic [79:0] txTwoStepStamp,
  input wire logic        txStampValid,
  input wire logic        txStampOneStep,
  input wire logic        rxFrameStart,
  input wire logic [79:0] rxStamp,
  input wire logic        rxStampValid
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic       txBusy;
  wire        txTake = ce && txFrameStart && !txBusy && (txPtpOp == 2'h1 || txPtpOp == 2'h2);
  wire  [8:0] reqKeep = rxPauseReq & ~pauseDone;
  // stamp sequencer occupancy, freed when the stamp is shown
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      txBusy <= 1'b0;
    else if (ce)
      txBusy <= txTake || (txBusy && !txStampValid);
  // bus transfer and stamp steps
  sequence s_take; ce && hsel && hready && htrans == 2'h2 && hsize == 3'h2; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_two_done; txStampValid && !txStampOneStep; endsequence
  property p_bus_okay; hresp == 1'b0; endproperty
  property p_bus_wait; s_take |=> s_wait; endproperty
  property p_glob; ce && rxPauseFrame && rxPauseGlobal |=> rxPauseValid == 9'h100
    && rxGlobalQuantaOut == $past(rxGlobalQuantaIn); endproperty
  property p_prio; ce && rxPauseFrame && !rxPauseGlobal |=> rxPauseValid == {1'b0,
    $past(rxPauseClassMask)} && (rxPauseReq[7:0] & $past(rxPauseClassMask))
    == $past(rxPauseClassMask); endproperty
  property p_req_hold; 1'b1 |=> (rxPauseReq & $past(reqKeep)) == $past(reqKeep); endproperty
  property p_req_clear; ce && !rxPauseFrame |=> (rxPauseReq & $past(pauseDone)) == 9'h0;
  endproperty
  property p_rx; ce && rxFrameStart |=> rxStampValid && rxStamp == $past(rxSystemTimer);
  endproperty
  property p_two; txTake && txPtpOp == 2'h2 |=> txTwoStepStamp == $past(txSystemTimer)
    ##1 s_two_done; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer not okay");
  a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");
  a_glob: assert property (p_glob) else $error("standard pause slot wrong");
  a_prio: assert property (p_prio) else $error("priority pause slots wrong");
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  a_req_clear: assert property (p_req_clear) else $error("request not cleared");
  a_rx: assert property (p_rx) else $error("receive stamp wrong");
  a_two: assert property (p_two) else $error("two-step stamp wrong");
endmodule
bind mac_pause_ptp mac_pause_ptp_monitor i_mon (.*);

// ==== testbench/client_model.sv ====
`timescale 1ns/1ns
// client side: timers on the block clock and pause completion
module client_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  lag,
  input  wire logic [8:0]  rxPauseReq,
  output logic      [8:0]  pauseDone,
  output logic      [79:0] txSystemTimer,
  output logic      [79:0] rxSystemTimer
);
  logic [47:0] sec;
  logic [31:0] ns;
  logic [3:0]  waitCnt;
  // 10 ns a clock, nanoseconds carry into seconds
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {sec, ns} <= 80'h0;
    else if (ns == 32'h3B9AC9F6)
      {sec, ns} <= {sec + 48'h1, 32'h0};
    else
      ns <= ns + 32'hA;
  // seconds above nanoseconds; receive timer runs slightly apart
  assign txSystemTimer = {sec, ns};
  assign rxSystemTimer = {sec, ns ^ 32'h5};
  // finish pending pauses lag plus one cycles after a request shows
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      waitCnt   <= 4'h0;
      pauseDone <= 9'h000;
    end
    else if (|rxPauseReq && pauseDone == 9'h000 && waitCnt != lag)
      waitCnt <= waitCnt + 4'h1;
    else
    begin
      waitCnt   <= 4'h0;
      pauseDone <= (waitCnt == lag) ? rxPauseReq : 9'h000;
    end
endmodule

// ==== testbench/mac_pause_report_ptp_time_inputs_bench.sv ====
`timescale 1ns/1ns
// drives pause frames, stamp starts and the register bus
module mac_pause_report_ptp_time_inputs_bench;
  logic             clk, rst_n, ce, hsel, hwrite, hreadyout, hresp, irq;
  logic             rxPauseFrame, rxPauseGlobal, txFrameStart, rxFrameStart;
  logic             txStampValid, txStampOneStep, rxStampValid;
  logic [1:0]       htrans, txPtpOp;
  logic [3:0]       lag;
  logic [7:0]       rxPauseClassMask;
  logic [8:0]       pauseDone, rxPauseReq, rxPauseValid;
  logic [15:0]      rxGlobalQuantaIn, rxGlobalQuantaOut, txPtpTag, txStampTag;
  logic [31:0]      haddr, hwdata, hrdata, rv;
  logic [63:0]      txCorrection;
  logic [79:0]      txSystemTimer, rxSystemTimer, txTwoStepStamp, txOneStepStamp, rxStamp;
  logic [7:0][15:0] rxPauseQuanta, rxPriorityQuantaOut;
  int               mismatches, totalChecks;
  // block with the client model on its far side
  mac_pause_ptp i_dut (.hsize(3'h2), .hready(hreadyout), .*);
  client_model i_client (.*);
  // compare and count
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task conclude;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // one single-word transfer, waits on hready twice
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do
      @(posedge clk);
    while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // one pause frame, returns where its report stands
  task automatic pause(input logic g, input logic [7:0] m, input logic [15:0] q);
    @(posedge clk);
    rxPauseFrame <= 1'b1;
    rxPauseGlobal <= g;
    rxPauseClassMask <= m;
    rxGlobalQuantaIn <= q;
    @(posedge clk);
    rxPauseFrame <= 1'b0;
    @(posedge clk);
  endtask
  // reset values, unmapped places and trim width
  task t_regs;
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, 32'(i * 4), 32'h0, rv);
      if (i != 3)
        chk(rv, 32'h0);
    end
    bus(1'b1, 32'h4, 32'hFFFFFFFF, rv);
    bus(1'b0, 32'h4, 32'h0, rv);
    chk(rv, 32'h7FF);
  endtask
  // priority frame to its classes, then standard frame to slot eight
  task t_pause;
    pause(1'b0, 8'h81, 16'h0);
    chk(rxPauseValid, 9'h081);
    chk(rxPauseReq, 9'h081);
    chk(rxPriorityQuantaOut[0], 16'h1000);
    chk(rxPriorityQuantaOut[7], 16'h1007);
    repeat (4) @(posedge clk);
    chk(rxPauseReq, 9'h081);
    for (int i = 0; i < 20 && rxPauseReq !== 9'h0; i++)
      @(posedge clk);
    chk(rxPauseReq, 9'h000);
    pause(1'b1, 8'hFF, 16'hBEEF);
    chk(rxPauseValid, 9'h100);
    chk(rxPauseReq, 9'h100);
    chk(rxGlobalQuantaOut, 16'hBEEF);
    chk(rxPriorityQuantaOut[7], 16'h1007);
  endtask
  // status masked, enabled, then cleared
  task t_irq;
    repeat (16) @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b1, 32'h10, 32'h1, rv);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    bus(1'b1, 32'hC, 32'h1F, rv);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    bus(1'b0, 32'h8, 32'h0, rv);
    chk(rv, 32'h0);
  endtask
  // clock enable low: a frame must not be taken
  task t_freeze;
    ce <= 1'b0;
    pause(1'b0, 8'h02, 16'h0);
    chk(rxPauseReq, 9'h000);
    chk(rxPauseValid, 9'h000);
    ce <= 1'b1;
  endtask
  // one stamp request with a receive stamp beside it
  task automatic t_tx(input logic [1:0] op, input logic [31:0] ctrl);
    logic [79:0] t, e;
    bus(1'b1, 32'h0, ctrl, rv);
    @(posedge clk);
    txFrameStart <= 1'b1;
    rxFrameStart <= 1'b1;
    txPtpOp <= op;
    txPtpTag <= {14'h1680, op};
    @(posedge clk);
    t = txSystemTimer;
    txFrameStart <= 1'b0;
    rxFrameStart <= 1'b0;
    for (int i = 0; i < 6 && txStampValid !== 1'b1; i++)
      @(posedge clk);
    chk(txStampValid, op == 2'h1 || op == 2'h2);
    if (txStampValid === 1'b1)
    begin
      e = ctrl[1] ? {t[79:64], 1'b0, t[62:0] + txCorrection[62:0]} : t;
      chk(txTwoStepStamp, e);
      chk(txStampTag, {14'h1680, op});
      chk(txStampOneStep, op == 2'h1 && ctrl[0]);
      e = ctrl[1] ? {e[79:64], 1'b0, e[62:0] + 63'h00FF_E000}
        : {t[79:32], t[31:0] + 32'hFF};
      if (txStampOneStep === 1'b1)
        chk(txOneStepStamp, e);
    end
  endtask
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // cut a hang short
  initial
  begin
    #100000;
    mismatches++;
    conclude;
  end
  // reset, then the scenarios
  initial
  begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata, rxPauseFrame, rxPauseGlobal} = '0;
    {rxPauseClassMask, rxGlobalQuantaIn, txFrameStart, rxFrameStart, txPtpOp} = '0;
    txPtpTag = 16'h0;
    ce = 1'b1;
    txCorrection = 64'h0000_0123_4567_8000;
    mismatches = 0;
    totalChecks = 0;
    lag = 4'h8;
    for (int i = 0; i < 8; i++)
      rxPauseQuanta[i] = 16'h1000 + 16'(i);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_pause;
    t_irq;
    t_freeze;
    for (int i = 0; i < 4; i++)
      t_tx(2'(i), 32'h1);
    t_tx(2'h1, 32'h0);
    t_tx(2'h1, 32'h3);
    conclude;
  end
endmodule
